// File: hw/occ_top.v
// Purpose: oscillator control register with clock switch sequencing
// Assumes: Avalon-MM slave, word aligned byte addresses, one clock
// Notes:   switch completes after settle ticks of the new source
// Notes on behaviour
// - post divider code 0..7 divides fast rc by 1,2,4..64,256; reset 1
// - read-only current source field at 14:12 reports the active source
// - writable next source field at 10:8 selects requested source
// - codes 6 and 7 act as divided fast rc
// - next source resets to configured initial source
// - switch request resets to the two-speed start configuration bit
// - control register writes ignored unless unlock sequence done first
// - aliases at +4, +8, +c clear, set, invert written ones
// - unimplemented bits read zero
// - config-derived fields load from config bits; fail flag resets zero
// - fail flag reads one once the monitor sees a failure
// - writing switch request starts switch; reads zero when done
// - selection lock freezes source selection
// - completed switch clears request and copies next to current
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "occ_defines.vh"
module occ_top (
   // clock and reset
   input  wire        i_clock,
   input  wire        i_sys_rst,
   // avalon-mm slave
   input  wire [7:0]  i_address,
   input  wire        i_read,
   input  wire        i_write,
   input  wire [31:0] i_writedata,
   input  wire [3:0]  i_byteenable,
   output reg  [31:0] o_readdata,
   output reg         o_waitrequest,
   // configuration word bits
   input  wire [2:0]  i_cfg_initial_source,
   input  wire        i_cfg_two_speed_start,
   // oscillator side (pins, synchronised here)
   input  wire        i_fail_detect,
   input  wire [5:0]  i_src_tick,
   input  wire        i_frc_tick,
   // outputs
   output reg  [2:0]  o_active_source,
   output reg         o_sysclk_tick,
   output reg         o_sleep_on_wait,
   output reg         o_secondary_osc_enable,
   output reg         o_irq
);
   // one-hot states of the switch sequencer and the unlock tracker
   localparam ST_IDLE   = 3'b001;
   localparam ST_SETTLE = 3'b010;
   localparam ST_DONE   = 3'b100;
   localparam UL_NONE   = 3'b001;
   localparam UL_HALF   = 3'b010;
   localparam UL_OPEN   = 3'b100;

   reg  [2:0]  div_q;
   reg  [2:0]  cur_q;
   reg  [2:0]  nxt_q;
   reg         lock_q;
   reg         slp_q;
   reg         cf_q;
   reg         secondary_oscillator_q;
   reg         sw_q;
   reg  [2:0]  st_q;
   reg  [2:0]  ul_q;
   reg  [7:0]  settle_q;
   reg  [1:0]  stat_q;
   reg  [1:0]  mask_q;
   reg         rst_seen_q;
   reg         fail_m_q;
   reg         fail_s_q;
   reg  [5:0]  tick_m_q;
   reg  [5:0]  tick_s_q;
   reg         frc_m_q;
   reg         frc_s_q;
   reg  [31:0] cur_word;
   reg  [31:0] new_word;
   reg  [31:0] be_mask;
   reg  [31:0] wmask;
   wire        div_tick;
   wire        access;
   wire        ctrl_hit;
   wire        wr_ok;
   wire        sel_tick;
   wire        nxt_tick;
   wire        sw_done;

   // map a source code to its tick lane; reserved codes use divided rc
   function [2:0] lane;
      input [2:0] code;
      begin
         case (code)
            `OCC_SRC_PLL:  lane = 3'd1;
            `OCC_SRC_PRIMARY_OSCILLATOR: lane = 3'd2;
            `OCC_SRC_SECONDARY_OSCILLATOR: lane = 3'd4;
            `OCC_SRC_LOW_POWER_RC_OSCILLATOR: lane = 3'd5;
            default:       lane = 3'd0;
         endcase
      end
   endfunction

   // two flip-flop synchronisers for oscillator-side inputs
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         fail_m_q <= 1'b0;
         fail_s_q <= 1'b0;
         tick_m_q <= 6'h00;
         tick_s_q <= 6'h00;
         frc_m_q  <= 1'b0;
         frc_s_q  <= 1'b0;
      end else begin
         fail_m_q <= i_fail_detect;
         fail_s_q <= fail_m_q;
         tick_m_q <= i_src_tick;
         tick_s_q <= tick_m_q;
         frc_m_q  <= i_frc_tick;
         frc_s_q  <= frc_m_q;
      end
   end

   // fast rc post divider feeds lane 0
   occ_frc_div u_div (
      .i_clock    (i_clock),
      .i_sys_rst  (i_sys_rst),
      .i_frc_tick (frc_s_q),
      .i_div_code (div_q),
      .o_div_tick (div_tick)
   );

   // tick of the running source and of the requested one
   assign sel_tick = (lane(cur_q) == 3'd0) ? div_tick
                                          : tick_s_q[lane(cur_q)];
   assign nxt_tick = (lane(nxt_q) == 3'd0) ? div_tick
                                          : tick_s_q[lane(nxt_q)];

   // bus decode; one wait cycle then answer
   assign access   = (i_read | i_write) & o_waitrequest;
   assign ctrl_hit = (i_address[7:4] == 4'h0) & (i_address[1:0] == 2'b00);
   assign wr_ok    = i_write & access & ctrl_hit & (ul_q == UL_OPEN);

   // current register image, unimplemented bits zero
   always @* begin
      cur_word = 32'h0000_0000;
      cur_word[`OCC_DIV_HI:`OCC_DIV_LO] = div_q;
      cur_word[`OCC_CUR_HI:`OCC_CUR_LO] = cur_q;
      cur_word[`OCC_NXT_HI:`OCC_NXT_LO] = nxt_q;
      cur_word[`OCC_LOCK_BIT] = lock_q;
      cur_word[`OCC_SLP_BIT]  = slp_q;
      cur_word[`OCC_CF_BIT]   = cf_q;
      cur_word[`OCC_SECONDARY_OSCILLATOR_BIT] = secondary_oscillator_q;
      cur_word[`OCC_SW_BIT]   = sw_q;
   end

   // write data after alias operation and byte enables
   always @* begin
      be_mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                 {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
      wmask   = `OCC_WR_MASK & be_mask;
      if (lock_q)
         wmask[`OCC_NXT_HI:`OCC_NXT_LO] = 3'h0;
      case (i_address[3:2])
         2'b01:   new_word = cur_word & ~(i_writedata & wmask);
         2'b10:   new_word = cur_word | (i_writedata & wmask);
         2'b11:   new_word = cur_word ^ (i_writedata & wmask);
         default: new_word = (cur_word & ~wmask) | (i_writedata & wmask);
      endcase
   end

   // one-cycle pulse as the new source takes over
   assign sw_done = (st_q == ST_DONE);

   // control register, switch sequencer and unlock tracker
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         div_q      <= 3'h0;
         cur_q      <= 3'h0;
         nxt_q      <= 3'h0;
         lock_q     <= 1'b0;
         slp_q      <= 1'b0;
         cf_q       <= 1'b0;
         secondary_oscillator_q     <= 1'b0;
         sw_q       <= 1'b0;
         st_q       <= ST_IDLE;
         ul_q       <= UL_NONE;
         settle_q   <= 8'h00;
         rst_seen_q <= 1'b1;
      end else begin
         // configuration bits caught just after reset release
         if (rst_seen_q) begin
            rst_seen_q <= 1'b0;
            nxt_q      <= i_cfg_initial_source;
            cur_q      <= i_cfg_initial_source;
            sw_q       <= i_cfg_two_speed_start;
         end else begin
            if (wr_ok) begin
               div_q  <= new_word[`OCC_DIV_HI:`OCC_DIV_LO];
               nxt_q  <= new_word[`OCC_NXT_HI:`OCC_NXT_LO];
               lock_q <= new_word[`OCC_LOCK_BIT];
               slp_q  <= new_word[`OCC_SLP_BIT];
               secondary_oscillator_q <= new_word[`OCC_SECONDARY_OSCILLATOR_BIT];
               sw_q   <= new_word[`OCC_SW_BIT];
            end
            // switch sequence
            case (st_q)
               ST_IDLE: begin
                  if (sw_q & ~wr_ok) begin
                     if (nxt_q == cur_q) begin
                        sw_q <= 1'b0;  // redundant switch aborted
                     end else begin
                        cf_q     <= 1'b0;
                        settle_q <= 8'h00;
                        st_q     <= ST_SETTLE;
                     end
                  end
               end
               ST_SETTLE: begin
                  if (nxt_tick) begin
                     if (settle_q == `OCC_SETTLE_CYC - 8'd1)
                        st_q <= ST_DONE;
                     else
                        settle_q <= settle_q + 8'd1;
                  end
               end
               ST_DONE: begin
                  cur_q <= nxt_q;
                  sw_q  <= 1'b0;
                  st_q  <= ST_IDLE;
               end
               default: st_q <= ST_IDLE;
            endcase
            // fail flag set wins over clears
            if (fail_s_q)
               cf_q <= 1'b1;
         end
         // unlock: key1 then key2 opens one write; any other unlock-address write or a control write shuts
         if (i_write & access & (i_address == `OCC_ADDR_UNLOCK)) begin
            if (i_writedata == `OCC_KEY1)
               ul_q <= UL_HALF;
            else if ((i_writedata == `OCC_KEY2) & (ul_q == UL_HALF))
               ul_q <= UL_OPEN;
            else
               ul_q <= UL_NONE;
         end else if (wr_ok) begin
            ul_q <= UL_NONE;
         end
      end
   end

   // interrupt status: bit0 switch done, bit1 clock fail; w1c, set wins
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         stat_q <= 2'b00;
         mask_q <= 2'b00;
      end else begin
         if (i_write & access & (i_address == `OCC_ADDR_IRQ_MASK))
            mask_q <= i_writedata[1:0];
         stat_q <= (stat_q & ~((i_write & access &
                    (i_address == `OCC_ADDR_IRQ_STAT)) ?
                    i_writedata[1:0] : 2'b00))
                   | {fail_s_q, sw_done};
      end
   end

   // avalon answer one cycle after the request; unmapped reads zero
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_waitrequest <= 1'b1;
         o_readdata    <= 32'h0000_0000;
      end else begin
         o_waitrequest <= ~((i_read | i_write) & o_waitrequest);
         if (i_read & access) begin
            if (ctrl_hit)
               o_readdata <= cur_word;
            else if (i_address == `OCC_ADDR_IRQ_STAT)
               o_readdata <= {30'h0, stat_q};
            else if (i_address == `OCC_ADDR_IRQ_MASK)
               o_readdata <= {30'h0, mask_q};
            else if (i_address == `OCC_ADDR_UNLOCK)
               o_readdata <= {29'h0, ul_q};
            else
               o_readdata <= 32'h0000_0000;
         end
      end
   end

   // registered outputs
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_active_source        <= 3'h0;
         o_sysclk_tick          <= 1'b0;
         o_sleep_on_wait        <= 1'b0;
         o_secondary_osc_enable <= 1'b0;
         o_irq                  <= 1'b0;
      end else begin
         o_active_source        <= cur_q;
         o_sysclk_tick          <= sel_tick;
         o_sleep_on_wait        <= slp_q;
         o_secondary_osc_enable <= secondary_oscillator_q;
         o_irq                  <= |(stat_q & mask_q);
      end
   end
endmodule

// File: hw/occ_defines.vh
// Purpose: constants for the oscillator control block
// Assumes: Avalon-MM word addressing on a byte address bus
// Notes:   offsets are byte addresses
`ifndef OCC_DEFINES_VH
`define OCC_DEFINES_VH

// register byte addresses
`define OCC_ADDR_CTRL      8'h00
`define OCC_ADDR_CTRL_CLR  8'h04
`define OCC_ADDR_CTRL_SET  8'h08
`define OCC_ADDR_CTRL_INV  8'h0c
`define OCC_ADDR_UNLOCK    8'h10
`define OCC_ADDR_IRQ_STAT  8'h14
`define OCC_ADDR_IRQ_MASK  8'h18

// field positions of oscillator_control
`define OCC_DIV_HI    26
`define OCC_DIV_LO    24
`define OCC_CUR_HI    14
`define OCC_CUR_LO    12
`define OCC_NXT_HI    10
`define OCC_NXT_LO    8
`define OCC_LOCK_BIT  7
`define OCC_SLP_BIT   4
`define OCC_CF_BIT    3
`define OCC_SECONDARY_OSCILLATOR_BIT  1
`define OCC_SW_BIT    0

// writable bits mask (cur source and fail flag excluded)
`define OCC_WR_MASK   32'h0700_0793
`define OCC_CF_MASK   32'h0000_0008

// unlock keys
`define OCC_KEY1      32'haa99_6655
`define OCC_KEY2      32'h5566_99aa

// source codes
`define OCC_SRC_FRC   3'h0
`define OCC_SRC_PLL   3'h1
`define OCC_SRC_PRIMARY_OSCILLATOR  3'h2
`define OCC_SRC_RSV   3'h3
`define OCC_SRC_SECONDARY_OSCILLATOR  3'h4
`define OCC_SRC_LOW_POWER_RC_OSCILLATOR  3'h5

// switch settle: new-source cycles before the switch
`define OCC_SETTLE_CYC 8'd10

`endif

// File: hw/occ_frc_div.v
// Purpose: fast rc post divider, produces a one-cycle enable pulse
// Assumes: i_frc_tick is a same-domain enable for the fast rc rate
// Notes:   code 7 divides by 256, not 128
`timescale 1ns/100ps
module occ_frc_div (
   // clock and reset
   input  wire       i_clock,
   input  wire       i_sys_rst,
   // control
   input  wire       i_frc_tick,
   input  wire [2:0] i_div_code,
   // output
   output reg        o_div_tick
);
   reg  [7:0] cnt_q;
   reg  [7:0] last;

   // terminal count for each divide code
   always @* begin
      case (i_div_code)
         3'h0:    last = 8'h00;
         3'h1:    last = 8'h01;
         3'h2:    last = 8'h03;
         3'h3:    last = 8'h07;
         3'h4:    last = 8'h0f;
         3'h5:    last = 8'h1f;
         3'h6:    last = 8'h3f;
         default: last = 8'hff;
      endcase
   end

   // counter, restarts when the code shrinks below it
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         cnt_q      <= 8'h00;
         o_div_tick <= 1'b0;
      end else begin
         o_div_tick <= 1'b0;
         if (i_frc_tick) begin
            if (cnt_q >= last) begin
               cnt_q      <= 8'h00;
               o_div_tick <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 8'h01;
            end
         end
      end
   end
endmodule

// File: tb/occ_top_asserts.sv
// Purpose: port checks for occ_top
// Assumes: one clock, sync reset
// Notes:   bound by name after the module
`timescale 1ns/100ps
module occ_top_asserts (
   // clock and reset
   input wire        i_clock,
   input wire        i_sys_rst,
   // bus
   input wire [7:0]  i_address,
   input wire        i_read,
   input wire        i_write,
   input wire [31:0] o_readdata,
   input wire        o_waitrequest,
   // config and outputs
   input wire [2:0]  i_cfg_initial_source,
   input wire [5:0]  i_src_tick,
   input wire        o_sysclk_tick,
   input wire [2:0]  o_active_source,
   input wire        o_sleep_on_wait,
   input wire        o_secondary_osc_enable,
   input wire        o_irq
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   // a taken request is answered at the next edge
   property p_ans;
      (i_read || i_write) && o_waitrequest |=> !o_waitrequest;
   endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   // the answer stands one cycle only
   property p_one;
      !o_waitrequest |=> o_waitrequest;
   endproperty
   a_one: assert property (p_one) else $error("long answer");
   // no answer without a request
   property p_why;
      $fell(o_waitrequest) |-> $past(i_read || i_write);
   endproperty
   a_why: assert property (p_why) else $error("stray answer");
   // unimplemented positions read zero
   property p_rsvd;
      !o_waitrequest && i_read && i_address == 8'h00
         |-> (o_readdata & 32'hf8ff_8864) == 32'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("bad zero");
   // sleep level moves only after a bus write
   property p_slp;
      $changed(o_sleep_on_wait) |-> $past(i_write) || $past(i_write, 2);
   endproperty
   a_slp: assert property (p_slp) else $error("sleep moved");
   // secondary enable moves only after a control write
   property p_secondary_oscillator;
      $changed(o_secondary_osc_enable)
         |-> $past(i_write && i_address < 8'h10, 2)
          || $past(i_write && i_address < 8'h10);
   endproperty
   a_secondary_oscillator: assert property (p_secondary_oscillator) else $error("secondary_oscillator moved");
   // source comes from config after reset
   property p_src;
      $fell(i_sys_rst) |-> ##[1:3] o_active_source == i_cfg_initial_source;
   endproperty
   a_src: assert property (p_src) else $error("reset source");
   // interrupt low after reset
   property p_irq;
      $fell(i_sys_rst) |-> !o_irq [*2];
   endproperty
   a_irq: assert property (p_irq) else $error("reset irq");
   // pll lane tick reaches the output three edges later
   property p_tick;
      o_active_source == 3'h1
         |-> o_sysclk_tick == $past(i_src_tick[1], 3);
   endproperty
   a_tick: assert property (p_tick) else $error("bad tick");
   // main scenarios
   c_sw: cover property ($changed(o_active_source));
   c_irq: cover property ($rose(o_irq));
   c_rd: cover property (i_read && !o_waitrequest);
endmodule
bind occ_top occ_top_asserts u_occ_top_asserts (
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_address(i_address),
   .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
   .o_waitrequest(o_waitrequest),
   .i_cfg_initial_source(i_cfg_initial_source),
   .i_src_tick(i_src_tick), .o_sysclk_tick(o_sysclk_tick),
   .o_active_source(o_active_source), .o_sleep_on_wait(o_sleep_on_wait),
   .o_secondary_osc_enable(o_secondary_osc_enable), .o_irq(o_irq)
);

// File: tb/tb.sv
// Purpose: self-checking bench for occ_top
// Assumes: one 20 MHz clock, sync reset
// Notes:   source ticks run at random
`timescale 1ns/100ps
`include "occ_defines.vh"
module tb;
   // drive and observe
   logic        i_clock = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic [7:0]  i_address = 8'h0;
   logic        i_read = 1'b0;
   logic        i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0;
   logic [2:0]  cfg = 3'h2;
   logic        ts = 1'b0;
   logic        fail = 1'b0;
   logic [5:0]  tick = 6'h0;
   logic        frc = 1'b0;
   wire  [31:0] o_readdata;
   wire         o_waitrequest;
   wire  [2:0]  o_active_source;
   wire         o_irq;
   wire         o_sleep_on_wait;
   wire         o_secondary_osc_enable;
   integer      bad_count = 0;
   integer      samples_checked = 0;
   logic [31:0] exp_q, q, d;
   logic [7:0]  a;
   logic [2:0]  nc;
   logic        u;
   localparam logic [31:0] M = 32'h0700_0012;

   occ_top u_occ_top (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .i_byteenable(4'hf), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .i_cfg_initial_source(cfg),
      .i_cfg_two_speed_start(ts), .i_fail_detect(fail),
      .i_src_tick(tick), .i_frc_tick(frc),
      .o_active_source(o_active_source), .o_sysclk_tick(),
      .o_sleep_on_wait(o_sleep_on_wait),
      .o_secondary_osc_enable(o_secondary_osc_enable), .o_irq(o_irq)
   );

   // clock and random source ticks
   initial forever #25 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      tick <= 6'($urandom);
      frc <= 1'($urandom);
   end

   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("Error at %0t: saw %h want %h", $time, s, e);
      end
   endtask

   task conclude;
      $display("checked %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one bus cycle, held until waitrequest is sampled low
   task bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int k;
      k = 0;
      i_address <= ad;
      i_writedata <= wd;
      i_write <= w;
      i_read <= !w;
      @(posedge i_clock);
      while (o_waitrequest !== 1'b0 && k < 50) begin
         @(posedge i_clock);
         k++;
      end
      q = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
      if (k >= 50) begin
         bad_count++;
         conclude;
      end
      @(posedge i_clock);
   endtask

   task unl;
      bus(1'b1, `OCC_ADDR_UNLOCK, `OCC_KEY1);
      bus(1'b1, `OCC_ADDR_UNLOCK, `OCC_KEY2);
   endtask

   // bounded wait for the active source to reach s
   task wait_src(input logic [2:0] s);
      int n;
      n = 0;
      while (o_active_source !== s && n < 400) begin
         @(posedge i_clock);
         n++;
      end
      if (n >= 400) begin
         bad_count++;
         conclude;
      end
   endtask

   task rst;
      i_sys_rst <= 1'b1;
      repeat (8) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      @(posedge i_clock);
      // read taken at the second edge still shows the reset request bit
      exp_q = {17'h0, cfg, 1'b0, cfg, 7'h0, ts};
      bus(1'b0, `OCC_ADDR_CTRL, 32'h0);
      chk(q, exp_q);
      // next equals current, so the request is dropped at once
      exp_q[0] = 1'b0;
      bus(1'b0, `OCC_ADDR_CTRL, 32'h0);
      chk(q, exp_q);
      chk({29'h0, o_active_source}, {29'h0, cfg});
      $display("test reset done");
   endtask

   // register model for direct and alias writes
   function logic [31:0] upd(input logic [31:0] e, input logic [7:0] ad,
                             input logic [31:0] wd);
      case (ad)
         8'h00: upd = (e & ~M) | (wd & M);
         8'h04: upd = e & ~(wd & M);
         8'h08: upd = e | (wd & M);
         default: upd = e ^ (wd & M);
      endcase
   endfunction

   initial begin
      void'($urandom(32'h6065));
      rst;
      // random writes, some without unlock
      for (int i = 0; i < 12; i++) begin
         a = 8'($urandom % 4) << 2;
         d = $urandom & 32'h0700_7012;
         if (a == 8'h0)
            d = d | (exp_q & 32'h700);
         u = 1'($urandom);
         if (u)
            unl;
         bus(1'b1, a, d);
         if (u)
            exp_q = upd(exp_q, a, d);
         bus(1'b0, `OCC_ADDR_CTRL, 32'h0);
         chk(q, exp_q);
         chk({30'h0, o_sleep_on_wait, o_secondary_osc_enable},
             {30'h0, exp_q[4], exp_q[1]});
      end
      // every divider code and every next source code but 3
      for (int c = 0; c < 8; c++) begin
         nc = (c == 3) ? 3'h0 : 3'(c);
         exp_q[26:24] = 3'(c);
         exp_q[10:8] = nc;
         unl;
         bus(1'b1, `OCC_ADDR_CTRL, exp_q);
         bus(1'b0, `OCC_ADDR_CTRL, 32'h0);
         chk(q, exp_q);
      end
      $display("test fields done");
      // clock switch to the pll lane
      unl;
      exp_q[10:8] = `OCC_SRC_PLL;
      bus(1'b1, `OCC_ADDR_CTRL, exp_q);
      unl;
      bus(1'b1, `OCC_ADDR_CTRL_SET, 32'h1);
      wait_src(`OCC_SRC_PLL);
      exp_q[14:12] = `OCC_SRC_PLL;
      bus(1'b0, `OCC_ADDR_CTRL, 32'h0);
      chk(q, exp_q);
      $display("test switch done");
      // switch-done event, masked then unmasked then cleared
      chk({31'h0, o_irq}, 32'h0);
      bus(1'b1, `OCC_ADDR_IRQ_MASK, 32'h3);
      repeat (2) @(posedge i_clock);
      chk({31'h0, o_irq}, 32'h1);
      bus(1'b1, `OCC_ADDR_IRQ_STAT, 32'h1);
      repeat (2) @(posedge i_clock);
      chk({31'h0, o_irq}, 32'h0);
      // clock failure sets the flag
      fail <= 1'b1;
      repeat (6) @(posedge i_clock);
      fail <= 1'b0;
      exp_q = exp_q | `OCC_CF_MASK;
      bus(1'b0, `OCC_ADDR_CTRL, 32'h0);
      chk(q, exp_q);
      repeat (2) @(posedge i_clock);
      chk({31'h0, o_irq}, 32'h1);
      $display("test irq done");
      // lock freezes the next source field
      unl;
      bus(1'b1, `OCC_ADDR_CTRL_SET, 32'h80);
      exp_q[7] = 1'b1;
      unl;
      bus(1'b1, `OCC_ADDR_CTRL, {exp_q[31:11], 3'h5, exp_q[7:0]});
      bus(1'b0, `OCC_ADDR_CTRL, 32'h0);
      chk(q, exp_q);
      bus(1'b0, 8'h1c, 32'h0);
      chk(q, 32'h0);
      $display("test lock done");
      // reserved code 6 runs on the divided fast rc lane
      unl;
      bus(1'b1, `OCC_ADDR_CTRL_CLR, 32'h80);
      exp_q[7] = 1'b0;
      exp_q[26:24] = 3'h0;
      exp_q[10:8] = 3'h6;
      unl;
      bus(1'b1, `OCC_ADDR_CTRL, exp_q | 32'h1);
      wait_src(3'h6);
      exp_q[14:12] = 3'h6;
      exp_q[3] = 1'b0;
      bus(1'b0, `OCC_ADDR_CTRL, 32'h0);
      chk(q, exp_q);
      $display("test reserved done");
      cfg <= `OCC_SRC_LOW_POWER_RC_OSCILLATOR;
      ts <= 1'b1;
      rst;
      conclude;
   end
endmodule
